/* File: dv/lsu_properties.sv */
// Port-level checker for the load/store byte lane unit
`timescale 1ns/1ps
`default_nettype none
module lsu_properties
	import lsu_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_big_endian,
	input wire logic i_issue,
	input wire logic [OPC_W-1:0] i_opcode_field,
	input wire logic [DATA_W-1:0] i_base,
	input wire logic [OFFS_W-1:0] i_offset,
	input wire logic [REG_W-1:0] i_target_register,
	input wire logic [REG_W-1:0] i_next_src_a,
	input wire logic [REG_W-1:0] i_next_src_b,
	input wire logic i_mem_ready,
	input wire logic o_mem_req,
	input wire logic o_mem_we,
	input wire logic [DATA_W-1:0] o_mem_addr,
	input wire logic [3:0] o_mem_be,
	input wire logic o_busy,
	input wire logic o_stall,
	input wire logic o_addr_err,
	input wire logic o_wb_en
);
	// *****
	// Helpers
	// *****
	// Address as the pipeline offers it; only an idle unit takes it
	wire logic [31:0] ea = i_base + {{16{i_offset[15]}}, i_offset};
	wire logic [1:0] ea_lo = ea[1:0];
	wire logic take = i_issue && !o_busy;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	AST_EA: assert property ($rose(o_mem_req) |-> o_mem_addr == ($past(ea) & 32'hFFFF_FFFC))
		else $error("address mismatch");
	AST_WORD_ERR: assert property (take && (i_opcode_field == OPC_LOAD_FULL_WORD
		|| i_opcode_field == OPC_STORE_WORD) && ea_lo != 2'h0 |=> o_addr_err) else $error("word");
	AST_HALF_ERR: assert property (take && (i_opcode_field == OPC_LOAD_HALF_SIGNED
		|| i_opcode_field == OPC_LOAD_HALF_ZERO_EXT || i_opcode_field == OPC_STORE_HALF)
		&& ea_lo[0] |=> o_addr_err) else $error("half");
	AST_BYTE_OK: assert property (take && (i_opcode_field == OPC_LOAD_BYTE_SIGNED
		|| i_opcode_field == OPC_STORE_SINGLE_BYTE) |=> !o_addr_err && o_mem_req) else $error("byte");
	AST_ERR_SUPPRESS: assert property (o_addr_err |-> !o_mem_req && !o_wb_en
		##1 !o_mem_req && !o_wb_en) else $error("err access");
	AST_LOAD_BE: assert property (o_mem_req && !o_mem_we |-> o_mem_be == 4'hF)
		else $error("load lanes");
	AST_SB_LANE: assert property ($rose(o_mem_req) && o_mem_we
		&& $past(i_opcode_field) == OPC_STORE_SINGLE_BYTE |-> o_mem_be ==
		($past(i_big_endian) ? 4'h8 >> $past(ea_lo) : 4'h1 << $past(ea_lo))) else $error("sb");
	AST_STALL: assert property (take && i_opcode_field == OPC_LOAD_BYTE_SIGNED
		&& (i_next_src_a == i_target_register || i_next_src_b == i_target_register)
		|=> o_stall) else $error("no stall");
	AST_NO_STALL: assert property (take && i_next_src_a != i_target_register
		&& i_next_src_b != i_target_register |=> !o_stall) else $error("false stall");
	AST_STALL_END: assert property (o_wb_en |-> !o_stall) else $error("stall");
	AST_WB: assert property (o_mem_req && !o_mem_we && i_mem_ready |=> o_wb_en && !o_mem_req)
		else $error("wb");
endmodule : lsu_properties
bind load_store_byte_lane_unit lsu_properties chk (.*);
`default_nettype wire

/* File: dv/mem_model.sv */
// Data memory model answering the unit's word requests
`timescale 1ns/1ps
`default_nettype none
module mem_model (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_req,
	input wire logic i_we,
	input wire logic [31:0] i_addr,
	input wire logic [3:0] i_be,
	input wire logic [31:0] i_wdata,
	input wire logic [1:0] i_delay,
	output logic o_ready,
	output logic [31:0] o_rdata
);
	// *****
	// Storage and answer
	// *****
	logic [31:0] mem [16];
	logic [1:0] cnt_r;
	wire logic [3:0] idx = i_addr[5:2];
	initial for (int i = 0; i < 16; i++) mem[i] = 32'h9E37_79B9 * (i + 1);
	// Outside the answer cycle the bus shows garbage, so a late sample is caught
	assign o_rdata = o_ready ? mem[idx] : ~mem[idx];
	// One-cycle answer after a chosen wait
	always_ff @(posedge i_sys_clk) begin
		if (i_rst || !i_req || o_ready) begin
			o_ready <= 1'b0;
			cnt_r <= 2'h0;
		end else if (cnt_r == i_delay) o_ready <= 1'b1;
		else cnt_r <= cnt_r + 2'h1;
	end
	// Only strobed bytes change
	always @(posedge i_sys_clk) if (o_ready && i_we) for (int i = 0; i < 4; i++)
		if (i_be[i]) mem[idx][8*i +: 8] <= i_wdata[8*i +: 8];
endmodule : mem_model
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the load/store byte lane unit
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import lsu_pkg::*;
;
	// *****
	// Signals
	// *****
	typedef struct {int k; logic [31:0] d; logic [3:0] be; logic [4:0] r;} exp_s;
	logic clk = 0, rst = 1, big = 0, issue = 0, rdy, req, we, busy, stall, aerr, wben, fwd = 0;
	logic [5:0] opc = 6'h00;
	logic [31:0] base = 0, tval = 0, rdata, maddr, wdata, wbd, fwd_val;
	logic [15:0] offs = 0;
	logic [4:0] treg = 0, src_a = 0, src_b = 0, wbr, fwd_reg;
	logic [1:0] dly = 0;
	logic [3:0] be;
	logic [31:0] shadow [16];
	logic [31:0] seed = 32'h0001_75AC;
	logic [5:0] ops [10] = '{6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h28, 6'h29, 6'h2B};
	exp_s q[$];
	int err_total = 0, checked = 0;

	initial forever #12.5 clk = ~clk;
	load_store_byte_lane_unit dut (.i_sys_clk(clk), .i_rst(rst), .i_big_endian(big),
		.i_issue(issue), .i_opcode_field(opc), .i_base(base), .i_offset(offs),
		.i_target_register(treg), .i_target_value(tval), .i_next_src_a(src_a),
		.i_next_src_b(src_b), .i_mem_ready(rdy), .i_mem_rdata(rdata), .o_mem_req(req),
		.o_mem_we(we), .o_mem_addr(maddr), .o_mem_be(be), .o_mem_wdata(wdata), .o_busy(busy),
		.o_stall(stall), .o_addr_err(aerr), .o_wb_en(wben), .o_wb_reg(wbr), .o_wb_data(wbd));
	mem_model mem (.i_sys_clk(clk), .i_rst(rst), .i_req(req), .i_we(we), .i_addr(maddr),
		.i_be(be), .i_wdata(wdata), .i_delay(dly), .o_ready(rdy), .o_rdata(rdata));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic bad(input string s);
		err_total++;
		$display("[FAIL] %0t %s", $time, s);
	endtask : bad
	task final_report;
		$display("mismatches %0d of %0d checks", err_total, checked);
		if (err_total == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : final_report
	// *****
	// Compare tasks
	// *****
	task automatic cmp_load(input exp_s e);
		checked++;
		if (e.k !== 0 || wbd !== e.d || wbr !== e.r) bad("load data");
	endtask : cmp_load
	task automatic cmp_store(input exp_s e);
		logic [31:0] m;
		for (int i = 0; i < 4; i++) m[8*i +: 8] = {8{e.be[i]}};
		checked++;
		if (e.k !== 1 || be !== e.be || (wdata & m) !== (e.d & m)) bad("store lanes");
	endtask : cmp_store
	task automatic cmp_err(input exp_s e);
		checked++;
		if (e.k !== 2) bad("address error");
	endtask : cmp_err
	// Results are paired with notes at mid-cycle, when outputs are settled
	always @(negedge clk) if (!rst) begin
		if (wben === 1'b1) cmp_load(q.pop_front());
		if (req === 1'b1 && we === 1'b1 && rdy === 1'b1) cmp_store(q.pop_front());
		if (aerr === 1'b1) cmp_err(q.pop_front());
	end
	// *****
	// One access with random fields and its expected result
	// *****
	task automatic acc(input logic [5:0] op);
		logic [31:0] w, ea, tv;
		logic [1:0] k, bl, hl, s;
		exp_s e;
		@(posedge clk);
		#1;
		seed = lfsr(seed);
		base = seed;
		seed = lfsr(seed);
		offs = seed[15:0];
		big = seed[16];
		treg = seed[17] ? 5'h01 : 5'h02;
		src_a = seed[18] ? treg : 5'h03;
		src_b = seed[21] ? treg : 5'h04;
		dly = seed[20:19];
		tval = lfsr(seed);
		seed = tval;
		opc = op;
		issue = 1'b1;
		// A merge right after a load into the same register sees the fresh value
		tv = (fwd && fwd_reg == treg && (op == 6'h22 || op == 6'h26)) ? fwd_val : tval;
		ea = base + {{16{offs[15]}}, offs};
		k = ea[1:0];
		bl = big ? 2'h3 - k : k;
		hl = big ? 2'h2 - k : k;
		w = shadow[ea[5:2]];
		e = '{0, 32'h0000_0000, 4'h0, treg};
		case (op)
			6'h20: e.d = {{24{w[8*bl+7]}}, w[8*bl +: 8]};
			6'h24: e.d = {24'h00_0000, w[8*bl +: 8]};
			6'h21: e.d = {{16{w[8*hl+15]}}, w[8*hl +: 16]};
			6'h25: e.d = {16'h0000, w[8*hl +: 16]};
			6'h23: e.d = w;
			6'h22: begin
				s = big ? k : 2'h3 - k;
				e.d = (w << (8 * s)) | (tv & ((32'h0000_0001 << (8 * s)) - 1));
			end
			6'h26: begin
				s = big ? 2'h3 - k : k;
				e.d = (w >> (8 * s)) | (tv & ~(32'hFFFF_FFFF >> (8 * s)));
			end
			6'h28: begin
				e.be = 4'h1 << bl;
				e.d = {4{tv[7:0]}};
			end
			6'h29: begin
				e.be = 4'h3 << hl;
				e.d = {2{tv[15:0]}};
			end
			default: begin
				e.be = 4'hF;
				e.d = tv;
			end
		endcase
		if (op[3]) e.k = 1;
		if (((op == 6'h21 || op == 6'h25 || op == 6'h29) && k[0]) ||
			((op == 6'h23 || op == 6'h2B) && k != 2'h0)) e.k = 2;
		q.push_back(e);
		if (e.k == 1) for (int i = 0; i < 4; i++) if (e.be[i]) shadow[ea[5:2]][8*i +: 8] = e.d[8*i +: 8];
		fwd = (e.k == 0);
		fwd_reg = treg;
		fwd_val = e.d;
		@(posedge clk);
		#1;
		issue = 1'b0;
		for (int n = 0; busy !== 1'b0; n++) begin
			if (n == 20) bad("busy stuck");
			if (n == 20) break;
			@(posedge clk);
			#1;
		end
	endtask : acc
	// *****
	// Main sequence and watchdog
	// *****
	// Every opcode once, then a random mix of sizes, offsets and byte orders
	initial begin
		for (int i = 0; i < 16; i++) shadow[i] = 32'h9E37_79B9 * (i + 1);
		repeat (4) @(posedge clk);
		#1;
		rst = 0;
		for (int i = 0; i < 220; i++) acc(ops[i < 10 ? i : seed[27:24] % 10]);
		#50;
		if (q.size() != 0) bad("results missing");
		final_report();
	end
	initial begin
		#(25 * 220 * 30);
		bad("timeout");
		final_report();
	end
endmodule : tb_top
`default_nettype wire

/* File: hdl/lane_decoder.sv */
// Byte lane decoder: lane mask, first lane and alignment check
`timescale 1ns/1ps
`default_nettype none
module lane_decoder
	import lsu_pkg::*;
(
	lane_if.dec lif
);

	// ****************************************
	// Alignment check
	// ****************************************
	wire logic ok_word;
	wire logic ok_triple;
	wire logic ok_half;
	assign ok_word = (lif.addr_lo == 2'h0);
	assign ok_triple = !lif.addr_lo[1]; // 00 or 01
	assign ok_half = !lif.addr_lo[0]; // 00 or 10
	assign lif.addr_err = (lif.size == SIZE_WORD) ? !ok_word :
		(lif.size == SIZE_TRIPLE) ? !ok_triple :
		(lif.size == SIZE_HALF) ? !ok_half : 1'b0;

	// ****************************************
	// Lane mask in little-endian lane numbering (lane k = bits 8k+7..8k)
	// ****************************************
	wire logic [3:0] offs_mask;
	wire logic [3:0] le_mask;
	wire logic [3:0] be_mask;
	assign offs_mask = (lif.size == SIZE_WORD) ? 4'hF :
		(lif.size == SIZE_TRIPLE) ? 4'h7 :
		(lif.size == SIZE_HALF) ? 4'h3 : 4'h1;
	assign le_mask = 4'((offs_mask << lif.addr_lo));
	// Big endian mirrors the lanes: offset k lives in lane 3-k
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_mirror
			assign be_mask[g] = le_mask[3-g];
		end
	endgenerate
	assign lif.lanes = lif.big_endian ? be_mask : le_mask;
	// Lane holding the lowest address byte
	assign lif.first_lane = lif.big_endian ? ~lif.addr_lo : lif.addr_lo;

endmodule : lane_decoder
`default_nettype wire

/* File: hdl/lane_if.sv */
// Interface carrying lane selection between the top and the lane decoder
`timescale 1ns/1ps
`default_nettype none
interface lane_if;
	import lsu_pkg::*;
	logic [1:0] addr_lo;
	size_e size;
	logic big_endian;
	logic [3:0] lanes;
	logic [1:0] first_lane;
	logic addr_err;
	modport dec(input addr_lo, input size, input big_endian,
		output lanes, output first_lane, output addr_err);
	modport user(output addr_lo, output size, output big_endian,
		input lanes, input first_lane, input addr_err);
endinterface : lane_if
`default_nettype wire

/* File: hdl/load_store_byte_lane_unit.sv */
// Load/store byte lane unit: address, lanes, extension, merge and interlock
//
// Summary of operation
// - Address is base register plus sign-extended 16-bit offset, nothing else.
// - Instruction reading a just-loaded register is stalled until the data returns.
// - Left/right part load right after a load merges into the fresh value.
// - Access size comes only from the opcode field.
// - Address names the lowest byte: MSB in big endian, LSB in little.
// - Misaligned word or halfword raises an address error.
// - Offset k uses lanes 31-8k..24-8k big endian, 8k+7..8k little.
// - Signed byte load sign-extends the addressed byte to 32 bits.
// - Unsigned byte load zero-extends the addressed byte to 32 bits.
// - Signed halfword load sign-extends the addressed halfword.
// - Unsigned halfword load zero-extends the addressed halfword.
// - Word load writes all four lanes unchanged.
// - Left-part load shifts bytes leftward and merges, keeping other bytes.
// - Right-part load shifts bytes rightward and merges, keeping other bytes.
// - Byte store writes source low byte to the addressed lane only.
// - Halfword store writes source low halfword placed by endianness.
// - Both byte orders supported by a setting; all lanes follow it.
// - Big endian offset zero sits at bits 31..24.
`timescale 1ns/1ps
`default_nettype none
module load_store_byte_lane_unit
	import lsu_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_big_endian,
	// Issue from pipeline
	input wire logic i_issue,
	input wire logic [OPC_W-1:0] i_opcode_field,
	input wire logic [DATA_W-1:0] i_base,
	input wire logic [OFFS_W-1:0] i_offset,
	input wire logic [REG_W-1:0] i_target_register,
	input wire logic [DATA_W-1:0] i_target_value,
	// Next instruction's source registers, for the interlock
	input wire logic [REG_W-1:0] i_next_src_a,
	input wire logic [REG_W-1:0] i_next_src_b,
	// Memory side
	input wire logic i_mem_ready,
	input wire logic [DATA_W-1:0] i_mem_rdata,
	output logic o_mem_req,
	output logic o_mem_we,
	output logic [DATA_W-1:0] o_mem_addr,
	output logic [3:0] o_mem_be,
	output logic [DATA_W-1:0] o_mem_wdata,
	// Pipeline side
	output logic o_busy,
	output logic o_stall,
	output logic o_addr_err,
	output logic o_wb_en,
	output logic [REG_W-1:0] o_wb_reg,
	output logic [DATA_W-1:0] o_wb_data
);

	// ****************************************
	// Opcode decode
	// ****************************************
	wire logic is_lb;
	wire logic is_lbu;
	wire logic is_lh;
	wire logic is_lhu;
	wire logic is_lw;
	wire logic is_ll;
	wire logic is_lr;
	wire logic is_sb;
	wire logic is_sh;
	wire logic is_sw;
	wire logic is_load;
	wire logic is_store;
	wire logic is_valid;
	assign is_lb = (i_opcode_field == OPC_LOAD_BYTE_SIGNED);
	assign is_lbu = (i_opcode_field == OPC_LOAD_BYTE_ZERO_EXT);
	assign is_lh = (i_opcode_field == OPC_LOAD_HALF_SIGNED);
	assign is_lhu = (i_opcode_field == OPC_LOAD_HALF_ZERO_EXT);
	assign is_lw = (i_opcode_field == OPC_LOAD_FULL_WORD);
	assign is_ll = (i_opcode_field == OPC_LOAD_LEFT_PART);
	assign is_lr = (i_opcode_field == OPC_LOAD_RIGHT_PART);
	assign is_sb = (i_opcode_field == OPC_STORE_SINGLE_BYTE);
	assign is_sh = (i_opcode_field == OPC_STORE_HALF);
	assign is_sw = (i_opcode_field == OPC_STORE_WORD);
	assign is_load = is_lb | is_lbu | is_lh | is_lhu | is_lw | is_ll | is_lr;
	assign is_store = is_sb | is_sh | is_sw;
	assign is_valid = is_load | is_store;

	// ****************************************
	// Effective address and size
	// ****************************************
	wire logic [DATA_W-1:0] eff_addr;
	wire logic [DATA_W-1:0] offs_ext;
	assign offs_ext = {{(DATA_W-OFFS_W){i_offset[OFFS_W-1]}}, i_offset};
	assign eff_addr = i_base + offs_ext;

	// Partial loads move whole words and never trap; the lane mask is rebuilt later
	size_e size_d;
	assign size_d = (is_lb | is_lbu | is_sb) ? SIZE_BYTE :
		(is_lh | is_lhu | is_sh) ? SIZE_HALF :
		(is_ll | is_lr) ? SIZE_BYTE : SIZE_WORD;

	lane_if lif();
	assign lif.addr_lo = eff_addr[1:0];
	assign lif.size = size_d;
	assign lif.big_endian = i_big_endian;
	lane_decoder u_lane_decoder (
		.lif(lif)
	);

	// ****************************************
	// Store data placement: replicate low byte/half into every lane
	// ****************************************
	wire logic [DATA_W-1:0] st_data;
	assign st_data = is_sb ? {4{i_target_value[7:0]}} :
		is_sh ? {2{i_target_value[15:0]}} : i_target_value;

	// ****************************************
	// Control state and captured access
	// ****************************************
	lsu_state_e state_r;
	lsu_state_e state_nxt;
	logic [DATA_W-1:0] addr_r;
	logic [3:0] be_r;
	logic [1:0] first_r;
	logic [OPC_W-1:0] opc_r;
	logic [REG_W-1:0] reg_r;
	logic [DATA_W-1:0] old_r;
	logic we_r;
	logic err_r;
	logic [DATA_W-1:0] wdata_r;
	logic [DATA_W-1:0] wb_data_r;
	logic wb_en_r;
	logic stall_r;
	logic big_r;
	logic fresh_r;
	wire logic take;
	wire logic bad;
	wire logic wb_ok;
	assign take = (state_r == ST_IDLE) && i_issue;
	assign bad = take && (!is_valid || lif.addr_err);
	assign wb_ok = (state_r == ST_MEM) && i_mem_ready;

	// Next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (take && !bad) begin
					state_nxt = ST_MEM;
				end
			end
			ST_MEM: begin
				if (i_mem_ready) begin
					state_nxt = ST_WB;
				end
			end
			ST_WB: state_nxt = ST_IDLE;
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ****************************************
	// Merge source for partial loads: forward a just-finished load
	// ****************************************
	// A flag rather than the one-cycle write-back pulse, since the next access
	// is taken only after the unit has gone idle
	wire logic [DATA_W-1:0] fwd_old;
	assign fwd_old = (fresh_r && (o_wb_reg == i_target_register)) ? wb_data_r :
		i_target_value;

	// Capture the access when it is taken
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			addr_r <= RST_DATA;
			be_r <= RST_BE;
			first_r <= 2'h0;
			opc_r <= 6'h00;
			reg_r <= 5'h00;
			old_r <= RST_DATA;
			we_r <= 1'b0;
			wdata_r <= RST_DATA;
		end else if (take) begin
			addr_r <= eff_addr;
			be_r <= lif.lanes;
			first_r <= lif.first_lane;
			opc_r <= i_opcode_field;
			reg_r <= i_target_register;
			old_r <= fwd_old;
			we_r <= is_store;
			wdata_r <= st_data;
		end
	end

	// ****************************************
	// Load data extraction
	// ****************************************
	wire logic [7:0] rd_byte;
	wire logic [15:0] rd_half;
	wire logic [4:0] sh_first;
	wire logic [1:0] k_off;
	assign sh_first = {first_r, 3'b000};
	assign rd_byte = 8'(i_mem_rdata >> sh_first);
	// Halfword: big endian low lane of the pair is first_r-1
	assign rd_half = addr_r[1] ^ big_r ? i_mem_rdata[31:16] : i_mem_rdata[15:0];
	assign k_off = addr_r[1:0];

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			big_r <= 1'b0;
		end else if (take) begin
			big_r <= i_big_endian;
		end
	end

	// Left/right parts: position in memory word given in big-endian offset terms
	wire logic [1:0] be_k;
	wire logic [4:0] sh_left;
	wire logic [4:0] sh_right;
	wire logic [DATA_W-1:0] keep_left;
	wire logic [DATA_W-1:0] keep_right;
	wire logic [DATA_W-1:0] left_val;
	wire logic [DATA_W-1:0] right_val;
	assign be_k = big_r ? k_off : ~k_off;
	assign sh_left = {be_k, 3'b000};
	assign sh_right = {~be_k, 3'b000};
	assign keep_left = ~(32'hFFFF_FFFF << sh_left);
	assign keep_right = ~(32'hFFFF_FFFF >> sh_right);
	assign left_val = (i_mem_rdata << sh_left) | (old_r & keep_left);
	assign right_val = (i_mem_rdata >> sh_right) | (old_r & keep_right);

	wire logic [DATA_W-1:0] ld_val;
	assign ld_val = (opc_r == OPC_LOAD_BYTE_SIGNED) ? {{24{rd_byte[7]}}, rd_byte} :
		(opc_r == OPC_LOAD_BYTE_ZERO_EXT) ? {24'h000000, rd_byte} :
		(opc_r == OPC_LOAD_HALF_SIGNED) ? {{16{rd_half[15]}}, rd_half} :
		(opc_r == OPC_LOAD_HALF_ZERO_EXT) ? {16'h0000, rd_half} :
		(opc_r == OPC_LOAD_LEFT_PART) ? left_val :
		(opc_r == OPC_LOAD_RIGHT_PART) ? right_val : i_mem_rdata;

	// ****************************************
	// Write-back and interlock
	// ****************************************
	// The stall holds the next instruction from issue to write-back when it reads
	// the target of any load that raises no address error
	wire logic hazard;
	assign hazard = take && !bad && is_load &&
		((i_next_src_a == i_target_register) || (i_next_src_b == i_target_register));

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			wb_en_r <= 1'b0;
			wb_data_r <= RST_DATA;
			o_wb_reg <= 5'h00;
			stall_r <= 1'b0;
			err_r <= 1'b0;
			fresh_r <= 1'b0;
		end else begin
			wb_en_r <= wb_ok && !we_r;
			// A fresh load result serves only the access taken next
			if (take) begin
				fresh_r <= 1'b0;
			end else if (wb_ok) begin
				fresh_r <= !we_r;
			end
			if (wb_ok) begin
				wb_data_r <= ld_val;
				o_wb_reg <= reg_r;
			end
			if (hazard) begin
				stall_r <= 1'b1;
			end else if (wb_ok) begin
				stall_r <= 1'b0;
			end
			err_r <= bad;
		end
	end

	// ****************************************
	// Memory request outputs
	// ****************************************
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_mem_req <= 1'b0;
			o_mem_we <= 1'b0;
			o_mem_addr <= RST_DATA;
			o_mem_be <= RST_BE;
			o_mem_wdata <= RST_DATA;
		end else if (take && !bad) begin
			o_mem_req <= 1'b1;
			o_mem_we <= is_store;
			o_mem_addr <= {eff_addr[31:2], 2'b00};
			o_mem_be <= is_store ? lif.lanes : 4'hF;
			o_mem_wdata <= st_data;
		end else if (wb_ok) begin
			o_mem_req <= 1'b0;
			o_mem_we <= 1'b0;
			o_mem_be <= RST_BE;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_busy <= 1'b0;
		end else begin
			o_busy <= (state_nxt != ST_IDLE);
		end
	end

	assign o_stall = stall_r;
	assign o_addr_err = err_r;
	assign o_wb_en = wb_en_r;
	assign o_wb_data = wb_data_r;

endmodule : load_store_byte_lane_unit
`default_nettype wire

/* File: hdl/lsu_pkg.sv */
// Package of constants and types for the load/store byte lane unit
package lsu_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int DATA_W = 32;
	localparam int OFFS_W = 16;
	localparam int REG_W = 5;
	localparam int OPC_W = 6;

	// ****************************************
	// Opcode field values (load/store group)
	// ****************************************
	localparam logic [5:0] OPC_LOAD_BYTE_SIGNED = 6'h20;
	localparam logic [5:0] OPC_LOAD_HALF_SIGNED = 6'h21;
	localparam logic [5:0] OPC_LOAD_LEFT_PART = 6'h22;
	localparam logic [5:0] OPC_LOAD_FULL_WORD = 6'h23;
	localparam logic [5:0] OPC_LOAD_BYTE_ZERO_EXT = 6'h24;
	localparam logic [5:0] OPC_LOAD_HALF_ZERO_EXT = 6'h25;
	localparam logic [5:0] OPC_LOAD_RIGHT_PART = 6'h26;
	localparam logic [5:0] OPC_STORE_SINGLE_BYTE = 6'h28;
	localparam logic [5:0] OPC_STORE_HALF = 6'h29;
	localparam logic [5:0] OPC_STORE_WORD = 6'h2B;

	// ****************************************
	// Access size codes
	// ****************************************
	typedef enum logic [1:0] {
		SIZE_BYTE = 2'h0,
		SIZE_HALF = 2'h1,
		SIZE_TRIPLE = 2'h2,
		SIZE_WORD = 2'h3
	} size_e;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [31:0] RST_DATA = 32'h0000_0000;
	localparam logic [3:0] RST_BE = 4'h0;

	// ****************************************
	// Control states: idle, access in memory, write-back
	// ****************************************
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_MEM = 2'b01,
		ST_WB = 2'b11
	} lsu_state_e;

endpackage : lsu_pkg
